// *** hdl/dci_dram.sv ***
// Purpose: dram end, samples and decodes command, address, clock enable
// Assumes: link ck equals mclk; link rst_n acts asynchronously
// Notes:   row state tracked per bank to choose the power-down kind
`timescale 1ns/100ps
`include "dci_regs.svh"
module dci_dram
   import dci_pkg::*;
(
   input  wire logic                          mclk,
   dci_link_if.dram                           link,
   input  wire logic                          rd_start,
   output logic                               act_vld,
   output logic [`DCI_BANK_W-1:0]             act_bank,
   output logic [`DCI_ROW_W-1:0]              act_row,
   output logic                               rw_vld,
   output logic                               rw_write,
   output logic [`DCI_BANK_W-1:0]             rw_bank,
   output logic [`DCI_COL_W-1:0]              rw_col,
   output logic                               rw_ap,
   output dci_burst_t                         rw_burst,
   output logic                               pre_vld,
   output logic [`DCI_BANKS-1:0]              pre_mask,
   output logic                               mrs_vld,
   output logic [1:0]                         mrs_sel,
   output logic [`DCI_ROW_W-1:0]              mrs_op,
   output logic [`DCI_BANKS-1:0]              open_banks,
   output dci_pwr_t                           pwr,
   output logic                               core_en,
   output logic                               odt_on,
   output logic                               strobe_en
);
   // ********************
   // input capture
   // ********************
   // capture on the clock edge itself; sref drops cs_n and odt, power-down drops cs_n only
   logic        cke_q;
   logic        cs_n_q;
   logic [2:0]  cmd_q;
   logic [2:0]  ba_q;
   logic [13:0] addr_q;
   logic        odt_q;
   // receivers follow the state held before this edge: a command sent on the
   // edge that leaves power-down is lost, so the controller wakes with a no-op
   wire         rx_cmd_on = (pwr == DCI_PW_ACTIVE);
   wire         rx_odt_on = (pwr != DCI_PW_SREF);
   // cke_q resets high, its level in normal use; a low reset value would fake
   // a power-down entry on the first edge after reset and drop a command
   always_ff @(posedge link.ck or negedge link.rst_n) begin
      if (!link.rst_n) begin
         cke_q  <= 1'b1;
         cs_n_q <= 1'b1;
         cmd_q  <= 3'h7;
         ba_q   <= 3'h0;
         addr_q <= 14'h0;
         odt_q  <= 1'b0;
      end else begin
         cke_q  <= link.cke;
         cs_n_q <= rx_cmd_on ? link.cs_n : 1'b1;
         cmd_q  <= {link.ras_n, link.cas_n, link.we_n};
         ba_q   <= link.ba;
         addr_q <= link.addr;
         odt_q  <= rx_odt_on ? link.odt : 1'b0;
      end
   end

   // ********************
   // command decode
   // ********************
   logic [`DCI_ROW_W-1:0] mr [0:`DCI_MR_CNT-1];
   wire [3:0] cmd      = {cs_n_q, cmd_q};
   wire       is_act   = (cmd == `DCI_CMD_ACT);
   wire       is_rd    = (cmd == `DCI_CMD_RD);
   wire       is_wr    = (cmd == `DCI_CMD_WR);
   wire       is_pre   = (cmd == `DCI_CMD_PRE);
   wire       is_mrs   = (cmd == `DCI_CMD_MRS);
   wire       is_ref   = (cmd == `DCI_CMD_REF);
   wire       otf_en   = mr[0][`DCI_MR_OTF_BIT];
   wire       ap_bit   = addr_q[`DCI_AP_BIT];
   wire [`DCI_BANKS-1:0] bank_hot = bank_dec(ba_q);
   wire [`DCI_BANKS-1:0] pre_sel  = ap_bit ? {`DCI_BANKS{1'b1}} : bank_hot;
   // a12 high keeps the full burst; low chops it to four
   wire       otf_bc4  = ~addr_q[`DCI_BC_BIT];
   wire       fix_bc4  = mr[0][`DCI_MR_BL_LSB];
   wire       bc4      = otf_en ? otf_bc4 : fix_bc4;
   // termination off in mr1 makes the termination pin a don't-care
   wire       rtt_off  = (mr[1][`DCI_MR1_RTT_LSB +: 2] == 2'b00);

   function automatic logic [`DCI_BANKS-1:0] bank_dec(input logic [2:0] b);
      bank_dec = `DCI_BANKS'(1) << b;
   endfunction

   // ********************
   // power state
   // ********************
   dci_pwr_t next_pwr;
   // banks as left by the command captured one edge earlier
   wire      all_idle = (open_banks == {`DCI_BANKS{1'b0}});
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         DCI_PW_ACTIVE: begin
            if (!cke_q) begin
               if (!all_idle)
                  next_pwr = DCI_PW_APD;
               else if (is_ref)
                  next_pwr = DCI_PW_SREF;
               else
                  next_pwr = DCI_PW_PPD;
            end
         end
         DCI_PW_PPD, DCI_PW_APD: begin
            if (cke_q)
               next_pwr = DCI_PW_ACTIVE;
         end
         DCI_PW_SREF: begin
            // unclocked exit: raw cke, not the registered copy
            if (link.cke)
               next_pwr = DCI_PW_ACTIVE;
         end
         default: next_pwr = DCI_PW_ACTIVE;
      endcase
   end

   // the raw-cke sref exit means the clock path must come back first;
   // the exit is then seen on the first edge after cke rises
   // an activate captured with cke low opens nothing: the device is going down
   wire next_act_open = is_act & cke_q;
   wire [`DCI_BANKS-1:0] next_open =
        (open_banks | (next_act_open ? bank_hot : '0))
        & ~(is_pre ? pre_sel : '0)
        & ~((is_rd | is_wr) & ap_bit ? bank_hot : '0);

   // ********************
   // outputs
   // ********************
   always_ff @(posedge link.ck or negedge link.rst_n) begin
      if (!link.rst_n) begin
         act_vld    <= 1'b0;
         act_bank   <= 3'h0;
         act_row    <= 14'h0;
         rw_vld     <= 1'b0;
         rw_write   <= 1'b0;
         rw_bank    <= 3'h0;
         rw_col     <= 10'h0;
         rw_ap      <= 1'b0;
         rw_burst   <= DCI_BURST_8;
         pre_vld    <= 1'b0;
         pre_mask   <= 8'h0;
         mrs_vld    <= 1'b0;
         mrs_sel    <= 2'h0;
         mrs_op     <= 14'h0;
         open_banks <= 8'h0;
         pwr        <= DCI_PW_ACTIVE;
         core_en    <= 1'b0;
         odt_on     <= 1'b0;
         strobe_en  <= 1'b0;
         // mode registers clear to fixed bl8, no on-the-fly, termination off
         for (int i = 0; i < `DCI_MR_CNT; i++) begin
            mr[i] <= 14'h0;
         end
      end else begin
         act_vld    <= is_act;
         act_bank   <= ba_q;
         act_row    <= addr_q;
         rw_vld     <= is_rd | is_wr;
         rw_write   <= is_wr;
         rw_bank    <= ba_q;
         rw_col     <= addr_q[`DCI_COL_W-1:0];
         rw_ap      <= ap_bit;
         rw_burst   <= bc4 ? DCI_BURST_4 : DCI_BURST_8;
         pre_vld    <= is_pre;
         pre_mask   <= pre_sel;
         mrs_vld    <= is_mrs;
         mrs_sel    <= ba_q[1:0];
         mrs_op     <= addr_q;
         if (is_mrs)
            mr[ba_q[1:0]] <= addr_q;
         open_banks <= next_open;
         pwr        <= next_pwr;
         core_en    <= cke_q & (next_pwr == DCI_PW_ACTIVE);
         // termination drops on the very edge that enters self refresh
         odt_on     <= odt_q & ~rtt_off & (next_pwr != DCI_PW_SREF);
         // gated by the state before the edge, so a strobe asked for on the
         // power-down entry edge still goes out
         strobe_en  <= rd_start & (pwr == DCI_PW_ACTIVE);
      end
   end
endmodule

// *** hdl/dci_regs.svh ***
// Purpose: command/address decode constants for the dram input side
// Assumes: one clock, mclk at 50 MHz
// Notes:   command codes are {cs_n, ras_n, cas_n, we_n}
`ifndef DCI_REGS_SVH
`define DCI_REGS_SVH
`define DCI_ROW_W        14
`define DCI_COL_W        10
`define DCI_BANK_W       3
`define DCI_AP_BIT       10
`define DCI_BC_BIT       12
`define DCI_CMD_MRS      4'h0
`define DCI_CMD_REF      4'h1
`define DCI_CMD_PRE      4'h2
`define DCI_CMD_ACT      4'h3
`define DCI_CMD_WR       4'h4
`define DCI_CMD_ZQ       4'h6
`define DCI_CMD_RD       4'h5
`define DCI_CMD_NOP      4'h7
`define DCI_CMD_DES      4'h8
`define DCI_MR_OTF_BIT   1
`define DCI_MR_BL_LSB    0
`define DCI_MR1_RTT_LSB  2
`define DCI_MR_CNT       4
`define DCI_BANKS        8
`endif

// *** hdl/dci_pkg.sv ***
// Purpose: shared types for the dram command/address input block
// Assumes: dci_regs.svh holds the numeric constants
// Notes:   types only
package dci_pkg;
   typedef enum logic [2:0] {
      DCI_PW_ACTIVE  = 3'b000,
      DCI_PW_PPD     = 3'b001,
      DCI_PW_APD     = 3'b010,
      DCI_PW_SREF    = 3'b011
   } dci_pwr_t;
   typedef enum logic [1:0] {
      DCI_BURST_8  = 2'b00,
      DCI_BURST_4  = 2'b01
   } dci_burst_t;
endpackage

// *** hdl/dci_link_if.sv ***
// Purpose: command/address link between controller and dram input side
// Assumes: one clock, the controller drives every wire
// Notes:   no two-way pins on this link
`timescale 1ns/100ps
interface dci_link_if;
   logic        ck;
   logic        rst_n;
   logic        cke;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [2:0]  ba;
   logic [13:0] addr;
   logic        odt;
   modport ctrl (output ck, rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
   modport dram (input  ck, rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

// *** hdl/dci_ctrl.sv ***
// Purpose: controller end, turns user requests into link commands
// Assumes: user request is a one-cycle pulse, link runs on mclk
// Notes:   one command per cycle; idle cycles drive deselect
`timescale 1ns/100ps
`include "dci_regs.svh"
module dci_ctrl
   import dci_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   srst,
   input  wire logic                   req,
   input  wire logic [3:0]             req_cmd,
   input  wire logic [2:0]             req_ba,
   input  wire logic [13:0]            req_addr,
   input  wire logic                   req_cke,
   input  wire logic                   req_odt,
   input  wire logic                   req_rank,
   input  wire logic                   dram_rst_n,
   dci_link_if.ctrl                    link,
   output logic                        sent
);
   // ********************
   // link drive
   // ********************
   logic        cs_n;
   logic [2:0]  cmd_bits;
   logic [2:0]  ba;
   logic [13:0] addr;
   logic        cke;
   logic        odt;
   logic        rst_n;
   // rank select as part of the command code; rank 1 is not this device
   wire         next_cs_n = ~req | req_rank;
   always_ff @(posedge mclk) begin
      if (srst) begin
         cs_n     <= 1'b1;
         cmd_bits <= 3'h7;
         ba       <= 3'h0;
         addr     <= 14'h0;
         cke      <= 1'b0;
         odt      <= 1'b0;
         rst_n    <= 1'b0;
         sent     <= 1'b0;
      end else begin
         cs_n     <= next_cs_n;
         cmd_bits <= req ? req_cmd[2:0] : 3'h7;
         ba       <= req_ba;
         addr     <= req_addr;
         cke      <= req_cke;
         odt      <= req_odt;
         rst_n    <= dram_rst_n;
         sent     <= req & ~req_rank;
      end
   end
   // values change on mclk falling-free timing: stable across the next dram edge
   assign link.ck    = mclk;
   assign link.cs_n  = cs_n;
   assign link.ras_n = cmd_bits[2];
   assign link.cas_n = cmd_bits[1];
   assign link.we_n  = cmd_bits[0];
   assign link.ba    = ba;
   assign link.addr  = addr;
   assign link.cke   = cke;
   assign link.odt   = odt;
   assign link.rst_n = rst_n;
endmodule

// *** verif/dci_checker.sv ***
// Purpose: link and decode checks beside the controller-to-dram link
// Assumes: decode outputs show two edges after the capture edge
// Notes:   commands are judged only while the dram is awake; deselects are judged on every edge
`timescale 1ns/100ps
module dci_checker
   import dci_pkg::*;
(
   input  wire logic        ck,
   input  wire logic        rst_n,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  ba,
   input  wire logic [13:0] addr,
   input  wire logic        act_vld,
   input  wire logic [2:0]  act_bank,
   input  wire logic [13:0] act_row,
   input  wire logic        rw_vld,
   input  wire logic [9:0]  rw_col,
   input  wire logic        rw_ap,
   input  wire logic        pre_vld,
   input  wire logic [7:0]  pre_mask,
   input  wire logic        mrs_vld,
   input  wire logic [1:0]  mrs_sel,
   input  wire logic [13:0] mrs_op,
   input  wire logic [7:0]  open_banks,
   input  wire dci_pwr_t    pwr,
   input  wire logic        core_en
);
   default clocking @(posedge ck); endclocking
   default disable iff (!rst_n);
   logic       cke_q;
   wire  [2:0] cmd  = {ras_n, cas_n, we_n};
   wire        live = cke && cke_q && pwr == DCI_PW_ACTIVE && !cs_n;
   wire        down = !cke && cke_q && pwr == DCI_PW_ACTIVE;
   always_ff @(posedge ck) begin
      cke_q <= cke;
   end
   a_act_row_bank: assert property (live && cmd == 3'b011 |-> ##2 act_vld
      && act_bank == $past(ba, 2) && act_row == $past(addr, 2)) else $error("activate decode");
   a_rw_col_ap: assert property (live && cmd[2:1] == 2'b10 |-> ##2 rw_vld
      && rw_col == $past(addr[9:0], 2) && rw_ap == $past(addr[10], 2)) else $error("rw decode");
   a_pre_scope: assert property (live && cmd == 3'b010 |-> ##2 pre_vld
      && pre_mask == ($past(addr[10], 2) ? 8'hff : 8'h01 << $past(ba, 2)))
      else $error("precharge mask");
   a_mrs_select: assert property (live && cmd == 3'b000 |-> ##2 mrs_vld
      && mrs_sel == $past(ba[1:0], 2) && mrs_op == $past(addr, 2)) else $error("mode load");
   a_cs_masks: assert property (cs_n |-> ##2 !(act_vld || rw_vld || pre_vld || mrs_vld))
      else $error("deselect decoded");
   a_core_off: assert property (pwr != DCI_PW_ACTIVE |-> !core_en) else $error("core on");
   a_pd_kind: assert property (down && !(!cs_n && cmd == 3'b001) |-> ##2
      pwr == ($past(open_banks, 1) != 8'h00 ? DCI_PW_APD : DCI_PW_PPD)) else $error("pd kind");
   a_sref_entry: assert property (down && !cs_n && cmd == 3'b001 ##1 open_banks == 8'h00
      |-> ##1 pwr == DCI_PW_SREF) else $error("self refresh entry");
   a_reset_clears: assert property (disable iff (1'b0) !rst_n |-> !act_vld
      && open_banks == 8'h00 && pwr == DCI_PW_ACTIVE) else $error("reset not clear");
   c_pre_all: cover property (pre_vld && pre_mask == 8'hff);
   c_apd: cover property (pwr == DCI_PW_APD);
   c_sref: cover property (pwr == DCI_PW_SREF);
endmodule

// *** verif/tb_top.sv ***
// Purpose: drives the controller end, compares dram decode with a model
// Assumes: both ends share mclk; one command per two cycles
// Notes:   stimulus from an lfsr so runs repeat exactly
`timescale 1ns/100ps
`include "dci_regs.svh"
module tb_top
   import dci_pkg::*;
   ;
   logic        mclk = 0, srst = 1, req = 0, req_cke = 0, req_odt = 0, req_rank = 0;
   logic        dram_rst_n = 0, rd_start = 0, sent, act_vld, rw_vld, rw_write, rw_ap, pre_vld;
   logic        mrs_vld, core_en, odt_on, strobe_en, sent_exp = 0;
   logic [3:0]  req_cmd = 0;
   logic [2:0]  req_ba = 0, act_bank, rw_bank;
   logic [13:0] req_addr = 0, act_row, mrs_op;
   logic [9:0]  rw_col;
   logic [7:0]  pre_mask, open_banks;
   logic [1:0]  mrs_sel, mr0 = 0;
   dci_burst_t  rw_burst;
   dci_pwr_t    pwr;
   int          n_mismatch = 0, checks = 0;
   bit [31:0]   lf = 32'h00012291;
   logic [31:0] q[$];
   dci_link_if link();
   dci_ctrl dci_ctrl_i(.mclk, .srst, .req, .req_cmd, .req_ba, .req_addr, .req_cke, .req_odt,
      .req_rank, .dram_rst_n, .link(link), .sent);
   dci_dram dci_dram_i(.mclk, .link(link), .rd_start, .act_vld, .act_bank, .act_row, .rw_vld,
      .rw_write, .rw_bank, .rw_col, .rw_ap, .rw_burst, .pre_vld, .pre_mask, .mrs_vld, .mrs_sel,
      .mrs_op, .open_banks, .pwr, .core_en, .odt_on, .strobe_en);
   dci_checker dci_checker_i(.ck(link.ck), .rst_n(link.rst_n), .cke(link.cke),
      .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
      .addr(link.addr), .act_vld, .act_bank, .act_row, .rw_vld, .rw_col, .rw_ap, .pre_vld,
      .pre_mask, .mrs_vld, .mrs_sel, .mrs_op, .open_banks, .pwr, .core_en);
   initial forever #10 mclk = ~mclk;
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pop(input logic [31:0] got);
      chk(got, q.size() != 0 ? q.pop_front() : 32'h0);
   endtask
   // a command is expected back only when it reaches this rank
   task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                       input logic k = 1'b1);
      logic [1:0] bst;
      bst = mr0[1] ? {1'b0, !a[12]} : {1'b0, mr0[0]};
      @(posedge mclk);
      req <= 1'b1;
      req_cmd <= c;
      req_ba <= b;
      req_addr <= a;
      req_cke <= k;
      req_odt <= 1'(rnd());
      rd_start <= 1'(rnd());
      @(posedge mclk);
      req <= 1'b0;
      if (!req_rank) begin
         case (c)
            `DCI_CMD_ACT: q.push_back({4'h1, 28'({b, a})});
            `DCI_CMD_RD, `DCI_CMD_WR:
               q.push_back({4'h2, 28'({c == `DCI_CMD_WR, b, a[9:0], a[10], bst})});
            `DCI_CMD_PRE: q.push_back({4'h3, 28'(a[10] ? 8'hff : 8'h01 << b)});
            `DCI_CMD_MRS: q.push_back({4'h4, 28'({b[1:0], a})});
            default: ;
         endcase
         if (c == `DCI_CMD_MRS && b == 3'h0)
            mr0 = a[1:0];
      end
   endtask
   task automatic pw(input dci_pwr_t e);
      repeat (6) @(posedge mclk);
      #1 chk(32'(pwr), 32'(e));
      chk(32'(core_en), 32'(e == DCI_PW_ACTIVE));
      chk(32'(strobe_en), 32'(e == DCI_PW_ACTIVE && rd_start));
   endtask
   always @(posedge mclk) begin
      if (!srst) chk(32'(sent), 32'(sent_exp));
      sent_exp <= req && !req_rank;
      if (act_vld) pop({4'h1, 28'({act_bank, act_row})});
      if (rw_vld) pop({4'h2, 28'({rw_write, rw_bank, rw_col, rw_ap, rw_burst})});
      if (pre_vld) pop({4'h3, 28'(pre_mask)});
      if (mrs_vld) pop({4'h4, 28'({mrs_sel, mrs_op})});
   end
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000 n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      dram_rst_n <= 1'b1;
      req_cke <= 1'b1;
      repeat (6) @(posedge mclk);
      for (int m = 0; m < 3; m++) begin
         send(`DCI_CMD_MRS, 3'h0, 14'(m));
         for (int i = 0; i < 8; i++) begin
            send(`DCI_CMD_ACT, 3'(i), 14'(rnd()));
            send((rnd() & 1) ? `DCI_CMD_RD : `DCI_CMD_WR, 3'(i), 14'(rnd()));
         end
         send(`DCI_CMD_PRE, 3'(rnd()), 14'(rnd()) & 14'h3bff);
         send(`DCI_CMD_PRE, 3'(rnd()), 14'h0400);
         send(`DCI_CMD_MRS, 3'(m + 1), 14'(rnd()));
      end
      $display("decode test done");
      req_rank <= 1'b1;
      send(`DCI_CMD_ACT, 3'h2, 14'h0123);
      req_rank <= 1'b0;
      $display("deselect test done");
      send(`DCI_CMD_ACT, 3'h5, 14'(rnd()));
      send(`DCI_CMD_NOP, 3'h0, 14'h0, 1'b0);
      pw(DCI_PW_APD);
      chk(32'(open_banks), 32'h20);
      // the no-op wakes the device; a command on the exit edge would be lost
      send(`DCI_CMD_NOP, 3'h0, 14'h0);
      send(`DCI_CMD_PRE, 3'h0, 14'h0400);
      pw(DCI_PW_ACTIVE);
      chk(32'(open_banks), 32'h0);
      send(`DCI_CMD_NOP, 3'h0, 14'h0, 1'b0);
      pw(DCI_PW_PPD);
      send(`DCI_CMD_NOP, 3'h0, 14'h0);
      pw(DCI_PW_ACTIVE);
      send(`DCI_CMD_REF, 3'h0, 14'h0, 1'b0);
      pw(DCI_PW_SREF);
      send(`DCI_CMD_NOP, 3'h0, 14'h0);
      pw(DCI_PW_ACTIVE);
      $display("power test done");
      send(`DCI_CMD_MRS, 3'h1, 14'h0004);
      req_odt <= 1'b1;
      rd_start <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(32'(odt_on), 32'h1);
      chk(32'(strobe_en), 32'h1);
      send(`DCI_CMD_MRS, 3'h1, 14'h0000);
      req_odt <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(32'(odt_on), 32'h0);
      $display("termination test done");
      chk(32'(q.size()), 32'h0);
      complete_run();
   end
endmodule
